// ---- bench/dtc_pulse_src.sv ----
/* Falling-edge pulse source for one count pin.
   Assumes the caller waits until each burst has ended. */
`timescale 1ns/1ps
`default_nettype none
module dtc_pulse_src (
    input wire logic clk_in,
    output logic pin_out
);
    initial pin_out = 1'b1;
    // Idle high; each pulse 4 cycles low then 4 high
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clk_in);
            pin_out <= 1'b0;
            repeat (4) @(posedge clk_in);
            pin_out <= 1'b1;
            repeat (4) @(posedge clk_in);
        end
    endtask : pulse
endmodule : dtc_pulse_src
`default_nettype wire

// ---- bench/dtc_timer_sva.sv ----
/* Port checker for dtc_timer, bound below.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_sva (
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    input wire logic TIMER_A_INT_ENABLE_IN,
    input wire logic TIMER_B_INT_ENABLE_IN,
    input wire logic TIMER_A_ACK_IN,
    input wire logic TIMER_B_ACK_IN,
    input wire logic TIMER_A_IRQ_OUT,
    input wire logic TIMER_B_IRQ_OUT
);
    default clocking dc @(posedge MCLK_IN);
    endclocking
    default disable iff (RST_IN);
    property p_rdy; PSEL_IN && !PENABLE_IN |=> PREADY_OUT; endproperty
    a_rdy: assert property (p_rdy) else $error("ready late");
    property p_acc;
        PREADY_OUT |-> PENABLE_IN && $past(PSEL_IN) && !$past(PENABLE_IN);
    endproperty
    a_acc: assert property (p_acc) else $error("stray ready");
    property p_err; PSLVERR_OUT |-> PREADY_OUT; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_rdz;
        PREADY_OUT && !PWRITE_IN |-> PRDATA_OUT[31:8] == 24'h000000;
    endproperty
    a_rdz: assert property (p_rdz) else $error("upper read bits set");
    property p_ia_en; TIMER_A_IRQ_OUT |-> $past(TIMER_A_INT_ENABLE_IN);
    endproperty
    a_ia_en: assert property (p_ia_en) else $error("irq a mask");
    property p_ib_en; TIMER_B_IRQ_OUT |-> $past(TIMER_B_INT_ENABLE_IN);
    endproperty
    a_ib_en: assert property (p_ib_en) else $error("irq b mask");
    property p_ia_hold;
        TIMER_A_IRQ_OUT && TIMER_A_INT_ENABLE_IN && !$past(TIMER_A_ACK_IN)
            && !$past(PSEL_IN) |=> TIMER_A_IRQ_OUT;
    endproperty
    a_ia_hold: assert property (p_ia_hold) else $error("a drop");
    property p_ib_hold;
        TIMER_B_IRQ_OUT && TIMER_B_INT_ENABLE_IN && !$past(TIMER_B_ACK_IN)
            && !$past(PSEL_IN) |=> TIMER_B_IRQ_OUT;
    endproperty
    a_ib_hold: assert property (p_ib_hold) else $error("b drop");
    c_ia: cover property (TIMER_A_IRQ_OUT);
    c_ib: cover property (TIMER_B_IRQ_OUT);
    c_err: cover property (PSLVERR_OUT);
endmodule : dtc_timer_sva
bind dtc_timer dtc_timer_sva u_sva (
    .MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN),
    .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .TIMER_A_ACK_IN(TIMER_A_ACK_IN),
    .TIMER_A_INT_ENABLE_IN(TIMER_A_INT_ENABLE_IN),
    .TIMER_B_INT_ENABLE_IN(TIMER_B_INT_ENABLE_IN),
    .TIMER_B_ACK_IN(TIMER_B_ACK_IN), .TIMER_A_IRQ_OUT(TIMER_A_IRQ_OUT),
    .TIMER_B_IRQ_OUT(TIMER_B_IRQ_OUT)
);
`default_nettype wire

// ---- bench/dtc_timer_test.sv ----
/* Self-checking bench for dtc_timer over APB.
   Assumes count pins are driven by dtc_pulse_src. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    miscompares++; \
    $display("CHECK FAILED %0t got %h want %h", $time, (g), (e)); \
    end end
module dtc_timer_test import dtc_pkg::*; ;
    logic clk, rst, psel, pen, pwr, gerr;
    logic ena, enb, acka, ackb, rdy, err, pa, pb, ia, ib;
    logic [3:0] strb;
    logic [7:0] padr;
    logic [31:0] pwd, prd, got;
    int miscompares = 0, samples_checked = 0, cyc = 0;
    dtc_timer DUT (
        .MCLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd),
        .PSTRB_IN(strb), .PRDATA_OUT(prd), .PREADY_OUT(rdy),
        .PSLVERR_OUT(err), .TIMER_A_COUNT_PIN_IN(pa),
        .TIMER_B_COUNT_PIN_IN(pb), .TIMER_A_INT_ENABLE_IN(ena),
        .TIMER_B_INT_ENABLE_IN(enb), .TIMER_A_ACK_IN(acka),
        .TIMER_B_ACK_IN(ackb), .TIMER_A_IRQ_OUT(ia), .TIMER_B_IRQ_OUT(ib)
    );
    dtc_pulse_src src_a (.clk_in(clk), .pin_out(pa));
    dtc_pulse_src src_b (.clk_in(clk), .pin_out(pb));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            test_done();
        end
    end
    task automatic test_done;
        $display("checks %0d bad %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done
    task automatic apb(input logic w, input logic [7:0] a, d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= {24'h000000, d};
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (rdy !== 1'b1) @(posedge clk);
        got = prd;
        gerr = err;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle
    task automatic t_reset;
        for (int i = 0; i < 7; i++) begin
            apb(0, 8'(i * 4), 8'h00);
            `CHK(got, 32'h00000000)
        end
        apb(1, 8'h1C, 8'h55);
        `CHK(gerr, 1'b1)
        strb <= 4'hE;
        apb(1, ADDR_A_LOW, 8'h55);
        strb <= 4'hF;
        apb(0, ADDR_A_LOW, 8'h00);
        `CHK(got, 32'h00000000)
        $display("end reset");
    endtask : t_reset
    task automatic t_m0;
        apb(1, ADDR_MODE, 8'h04);
        apb(1, ADDR_A_LOW, 8'h1E);
        apb(1, ADDR_A_HIGH, 8'hFF);
        apb(1, ADDR_CTRL, 8'h01);
        src_a.pulse(1);
        apb(0, ADDR_A_LOW, 8'h00);
        `CHK(got[4:0], 5'h1F)
        `CHK(ia, 1'b0)
        src_a.pulse(1);
        apb(0, ADDR_A_LOW, 8'h00);
        `CHK(got[4:0], 5'h00)
        apb(0, ADDR_A_HIGH, 8'h00);
        `CHK(got[7:0], 8'h00)
        idle(3);
        `CHK(ia, 1'b1)
        apb(0, ADDR_CTRL, 8'h00);
        `CHK(got[3:0], 4'h3)
        @(posedge clk);
        acka <= 1'b1;
        @(posedge clk);
        acka <= 1'b0;
        idle(3);
        `CHK(ia, 1'b0)
        $display("end mode 0");
    endtask : t_m0
    task automatic t_m1;
        apb(1, ADDR_CTRL, 8'h00);
        apb(1, ADDR_MODE, 8'h05);
        apb(1, ADDR_A_LOW, 8'hFF);
        apb(1, ADDR_A_HIGH, 8'h12);
        src_a.pulse(1);
        apb(0, ADDR_A_LOW, 8'h00);
        `CHK(got[7:0], 8'hFF)
        apb(1, ADDR_CTRL, 8'h01);
        src_a.pulse(1);
        apb(1, ADDR_CTRL, 8'h00);
        src_a.pulse(1);
        apb(0, ADDR_A_HIGH, 8'h00);
        `CHK(got[7:0], 8'h13)
        apb(1, ADDR_CTRL, 8'h01);
        src_a.pulse(1);
        apb(0, ADDR_A_LOW, 8'h00);
        `CHK(got[7:0], 8'h01)
        $display("end mode 1");
    endtask : t_m1
    task automatic t_b2;
        apb(1, ADDR_CTRL, 8'h00);
        ena <= 1'b0;
        enb <= 1'b0;
        apb(1, ADDR_MODE, 8'h66);
        apb(1, ADDR_B_HIGH, 8'hFE);
        apb(1, ADDR_B_LOW, 8'hFF);
        apb(1, ADDR_A_HIGH, 8'h80);
        apb(1, ADDR_A_LOW, 8'hFF);
        apb(1, ADDR_CTRL, 8'h05);
        src_b.pulse(1);
        apb(0, ADDR_B_LOW, 8'h00);
        `CHK(got[7:0], 8'hFE)
        apb(0, ADDR_CTRL, 8'h00);
        `CHK(got[3:0], 4'hD)
        `CHK(ib, 1'b0)
        src_a.pulse(1);
        apb(0, ADDR_A_LOW, 8'h00);
        `CHK(got[7:0], 8'h80)
        apb(0, ADDR_A_HIGH, 8'h00);
        `CHK(got[7:0], 8'h80)
        `CHK(ia, 1'b0)
        @(posedge clk);
        ena <= 1'b1;
        enb <= 1'b1;
        idle(4);
        `CHK(ia, 1'b1)
        `CHK(ib, 1'b1)
        @(posedge clk);
        acka <= 1'b1;
        ackb <= 1'b1;
        @(posedge clk);
        acka <= 1'b0;
        ackb <= 1'b0;
        idle(3);
        `CHK(ia, 1'b0)
        `CHK(ib, 1'b0)
        src_b.pulse(1);
        apb(0, ADDR_B_LOW, 8'h00);
        `CHK(got[7:0], 8'hFF)
        $display("end reload");
    endtask : t_b2
    task automatic t_split;
        apb(1, ADDR_CTRL, 8'h00);
        apb(1, ADDR_MODE, 8'h13);
        apb(1, ADDR_FREQ, 8'h03);
        apb(1, ADDR_A_HIGH, 8'hFF);
        apb(1, ADDR_A_LOW, 8'h00);
        apb(1, ADDR_B_LOW, 8'h00);
        apb(1, ADDR_CTRL, 8'h04);
        idle(10);
        apb(0, ADDR_CTRL, 8'h00);
        `CHK(got[3:0], 4'hC)
        apb(0, ADDR_B_LOW, 8'h00);
        `CHK(got[7:0], 8'h00)
        apb(0, ADDR_A_LOW, 8'h00);
        `CHK(got[7:0], 8'h00)
        apb(1, ADDR_MODE, 8'h30);
        apb(1, ADDR_CTRL, 8'h04);
        idle(10);
        apb(0, ADDR_B_LOW, 8'h00);
        `CHK(got[7:0], 8'h00)
        $display("end split");
    endtask : t_split
    task automatic t_div;
        apb(1, ADDR_CTRL, 8'h00);
        apb(1, ADDR_MODE, 8'h01);
        apb(1, ADDR_FREQ, 8'h00);
        apb(1, ADDR_A_LOW, 8'h00);
        apb(1, ADDR_CTRL, 8'h01);
        repeat (120) @(posedge clk);
        apb(1, ADDR_CTRL, 8'h00);
        apb(0, ADDR_A_LOW, 8'h00);
        `CHK(got[7:0] inside {8'h0A, 8'h0B}, 1'b1)
        $display("end divide");
    endtask : t_div
    initial begin
        rst <= 1'b1;
        psel <= 1'b0;
        pen <= 1'b0;
        pwr <= 1'b0;
        padr <= 8'h00;
        pwd <= 32'h00000000;
        strb <= 4'hF;
        ena <= 1'b1;
        enb <= 1'b1;
        acka <= 1'b0;
        ackb <= 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_m0();
        t_m1();
        t_b2();
        t_split();
        t_div();
        test_done();
    end
endmodule : dtc_timer_test
`default_nettype wire

// ---- rtl/dtc_pkg.sv ----
/*
 * Package for the dual timer/counter: register offsets, field positions,
 * reset values, modes and the clock divide ratio.
 * Assumes a 32-bit APB slave with one register per aligned word.
 */
package dtc_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_FREQ = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_A_LOW = 8'h0C;
    localparam logic [7:0] ADDR_A_HIGH = 8'h10;
    localparam logic [7:0] ADDR_B_LOW = 8'h14;
    localparam logic [7:0] ADDR_B_HIGH = 8'h18;
    // Mode register fields
    localparam int MODE_A_LSB = 0;
    localparam int MODE_A_SEL = 2;
    localparam int MODE_B_LSB = 4;
    localparam int MODE_B_SEL = 6;
    localparam logic [7:0] MODE_MASK = 8'h77;
    // Frequency control fields
    localparam int FREQ_A_DIV = 0;
    localparam int FREQ_B_DIV = 1;
    localparam logic [7:0] FREQ_MASK = 8'h03;
    // Control register fields
    localparam int CTRL_A_RUN = 0;
    localparam int CTRL_A_OVF = 1;
    localparam int CTRL_B_RUN = 2;
    localparam int CTRL_B_OVF = 3;
    localparam logic [7:0] CTRL_MASK = 8'h0F;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] MASK_13_LOW = 8'h1F;
    localparam logic [7:0] BYTE_ONES = 8'hFF;
    localparam int DIV_RATIO = 12;
    localparam logic [3:0] DIV_LAST = 4'(DIV_RATIO - 1);

    typedef enum logic [1:0] {
        MODE_13BIT,
        MODE_16BIT,
        MODE_RELOAD,
        MODE_SPLIT
    } dtc_mode_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } dtc_count_t;
endpackage : dtc_pkg

// ---- rtl/dtc_timer.sv ----
/*
 * Two timer/counters, A and B, with 13-bit, 16-bit, 8-bit reload and
 * (timer A only) split modes, behind an APB slave.
 * Assumes count pins are asynchronous and the overflow flags are cleared
 * by software or by the interrupt controller's acknowledge pulses.
 */
`timescale 1ns/1ps
`default_nettype none

module dtc_timer
    import dtc_pkg::*;
(
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [3:0] PSTRB_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic TIMER_A_COUNT_PIN_IN,
    input wire logic TIMER_B_COUNT_PIN_IN,
    input wire logic TIMER_A_INT_ENABLE_IN,
    input wire logic TIMER_B_INT_ENABLE_IN,
    input wire logic TIMER_A_ACK_IN,
    input wire logic TIMER_B_ACK_IN,
    output logic TIMER_A_IRQ_OUT,
    output logic TIMER_B_IRQ_OUT
);
    logic [7:0] mode_q;
    logic [7:0] freq_q;
    logic timer_a_run_q;
    logic timer_b_run_q;
    logic timer_a_overflow_flag_q;
    logic timer_b_overflow_flag_q;
    dtc_count_t cnt_a_q, cnt_a_d;
    dtc_count_t cnt_b_q, cnt_b_d;
    logic [3:0] div_q;
    logic tick12;
    logic [2:0] pin_a_q, pin_b_q;
    logic pin_a_lvl_q, pin_b_lvl_q;
    logic fall_a, fall_b;
    logic ovf_a, ovf_b, ovf_split;
    logic wr_en, lane0;
    logic [31:0] rdata_d;
    logic rd_err;

    dtc_mode_t mode_a, mode_b;
    logic tick_a, tick_b, tick_ah, b_enabled;

    assign mode_a = dtc_mode_t'(mode_q[MODE_A_LSB +: 2]);
    assign mode_b = dtc_mode_t'(mode_q[MODE_B_LSB +: 2]);

    // Prescaler for the divided clock
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN || div_q == DIV_LAST) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end
    assign tick12 = (div_q == DIV_LAST);

    // Count pins: three-stage sync, level accepted when stages 2 and 3 agree
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            pin_a_q <= 3'h7;
            pin_b_q <= 3'h7;
            pin_a_lvl_q <= 1'b1;
            pin_b_lvl_q <= 1'b1;
        end else begin
            pin_a_q <= {pin_a_q[1:0], TIMER_A_COUNT_PIN_IN};
            pin_b_q <= {pin_b_q[1:0], TIMER_B_COUNT_PIN_IN};
            if (pin_a_q[1] == pin_a_q[2]) begin
                pin_a_lvl_q <= pin_a_q[2];
            end
            if (pin_b_q[1] == pin_b_q[2]) begin
                pin_b_lvl_q <= pin_b_q[2];
            end
        end
    end
    assign fall_a = pin_a_lvl_q && (pin_a_q[1] == pin_a_q[2]) && !pin_a_q[2];
    assign fall_b = pin_b_lvl_q && (pin_b_q[1] == pin_b_q[2]) && !pin_b_q[2];

    // Count sources
    always_comb begin
        if (mode_q[MODE_A_SEL]) begin
            tick_a = fall_a;
        end else begin
            tick_a = freq_q[FREQ_A_DIV] ? 1'b1 : tick12;
        end
        if (mode_q[MODE_B_SEL]) begin
            tick_b = fall_b;
        end else begin
            tick_b = freq_q[FREQ_B_DIV] ? 1'b1 : tick12;
        end
        // Split high byte counts the internal clock only, divided unless FREQ_A_DIV is set
        tick_ah = freq_q[FREQ_A_DIV] ? 1'b1 : tick12;
        b_enabled = timer_b_run_q && (mode_a != MODE_SPLIT)
            && (mode_b != MODE_SPLIT);
    end

    // Timer A counting
    always_comb begin
        cnt_a_d = cnt_a_q;
        ovf_a = 1'b0;
        ovf_split = 1'b0;
        if (timer_a_run_q && tick_a) begin
            case (mode_a)
                MODE_13BIT: begin
                    if ((cnt_a_q.low & MASK_13_LOW) == MASK_13_LOW) begin
                        cnt_a_d.low = cnt_a_q.low & ~MASK_13_LOW;
                        cnt_a_d.high = cnt_a_q.high + 8'h01;
                        ovf_a = (cnt_a_q.high == BYTE_ONES);
                    end else begin
                        cnt_a_d.low = cnt_a_q.low + 8'h01;
                    end
                end
                MODE_16BIT: begin
                    {cnt_a_d.high, cnt_a_d.low} = {cnt_a_q.high, cnt_a_q.low}
                        + 16'h0001;
                    ovf_a = (cnt_a_q == {BYTE_ONES, BYTE_ONES});
                end
                MODE_RELOAD: begin
                    if (cnt_a_q.low == BYTE_ONES) begin
                        cnt_a_d.low = cnt_a_q.high;
                        ovf_a = 1'b1;
                    end else begin
                        cnt_a_d.low = cnt_a_q.low + 8'h01;
                    end
                end
                default: begin
                    cnt_a_d.low = cnt_a_q.low + 8'h01;
                    ovf_a = (cnt_a_q.low == BYTE_ONES);
                end
            endcase
        end
        if (mode_a == MODE_SPLIT && timer_b_run_q && tick_ah) begin
            cnt_a_d.high = cnt_a_q.high + 8'h01;
            ovf_split = (cnt_a_q.high == BYTE_ONES);
        end
    end

    // Timer B counting
    always_comb begin
        cnt_b_d = cnt_b_q;
        ovf_b = 1'b0;
        if (b_enabled && tick_b) begin
            case (mode_b)
                MODE_13BIT: begin
                    if ((cnt_b_q.low & MASK_13_LOW) == MASK_13_LOW) begin
                        cnt_b_d.low = cnt_b_q.low & ~MASK_13_LOW;
                        cnt_b_d.high = cnt_b_q.high + 8'h01;
                        ovf_b = (cnt_b_q.high == BYTE_ONES);
                    end else begin
                        cnt_b_d.low = cnt_b_q.low + 8'h01;
                    end
                end
                MODE_16BIT: begin
                    {cnt_b_d.high, cnt_b_d.low} = {cnt_b_q.high, cnt_b_q.low}
                        + 16'h0001;
                    ovf_b = (cnt_b_q == {BYTE_ONES, BYTE_ONES});
                end
                MODE_RELOAD: begin
                    if (cnt_b_q.low == BYTE_ONES) begin
                        cnt_b_d.low = cnt_b_q.high;
                        ovf_b = 1'b1;
                    end else begin
                        cnt_b_d.low = cnt_b_q.low + 8'h01;
                    end
                end
                default: begin
                    cnt_b_d = cnt_b_q;
                end
            endcase
        end
    end

    // APB decode; zero wait states
    assign wr_en = PSEL_IN && PENABLE_IN && PWRITE_IN;
    assign lane0 = PSTRB_IN[0];

    // Counter registers: bus write takes priority over counting
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            cnt_a_q <= '0;
            cnt_b_q <= '0;
        end else begin
            cnt_a_q <= cnt_a_d;
            cnt_b_q <= cnt_b_d;
            if (wr_en && lane0) begin
                if (PADDR_IN == ADDR_A_LOW) begin
                    cnt_a_q.low <= PWDATA_IN[7:0];
                end else if (PADDR_IN == ADDR_A_HIGH) begin
                    cnt_a_q.high <= PWDATA_IN[7:0];
                end else if (PADDR_IN == ADDR_B_LOW) begin
                    cnt_b_q.low <= PWDATA_IN[7:0];
                end else if (PADDR_IN == ADDR_B_HIGH) begin
                    cnt_b_q.high <= PWDATA_IN[7:0];
                end
            end
        end
    end

    // Configuration and control bits
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            mode_q <= RESET_BYTE;
            freq_q <= RESET_BYTE;
            timer_a_run_q <= 1'b0;
            timer_b_run_q <= 1'b0;
        end else if (wr_en && lane0) begin
            if (PADDR_IN == ADDR_MODE) begin
                mode_q <= PWDATA_IN[7:0] & MODE_MASK;
            end else if (PADDR_IN == ADDR_FREQ) begin
                freq_q <= PWDATA_IN[7:0] & FREQ_MASK;
            end else if (PADDR_IN == ADDR_CTRL) begin
                timer_a_run_q <= PWDATA_IN[CTRL_A_RUN];
                timer_b_run_q <= PWDATA_IN[CTRL_B_RUN];
            end
        end
    end

    // Overflow flags: set wins over any clear
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            timer_a_overflow_flag_q <= 1'b0;
            timer_b_overflow_flag_q <= 1'b0;
        end else begin
            if (ovf_a) begin
                timer_a_overflow_flag_q <= 1'b1;
            end else if (TIMER_A_ACK_IN || (wr_en && lane0
                    && PADDR_IN == ADDR_CTRL)) begin
                timer_a_overflow_flag_q <= TIMER_A_ACK_IN ? 1'b0
                    : PWDATA_IN[CTRL_A_OVF];
            end
            if (ovf_b || ovf_split) begin
                timer_b_overflow_flag_q <= 1'b1;
            end else if (TIMER_B_ACK_IN || (wr_en && lane0
                    && PADDR_IN == ADDR_CTRL)) begin
                timer_b_overflow_flag_q <= TIMER_B_ACK_IN ? 1'b0
                    : PWDATA_IN[CTRL_B_OVF];
            end
        end
    end

    // Read mux
    always_comb begin
        rdata_d = '0;
        rd_err = 1'b0;
        if (PADDR_IN == ADDR_MODE) begin
            rdata_d[7:0] = mode_q;
        end else if (PADDR_IN == ADDR_FREQ) begin
            rdata_d[7:0] = freq_q;
        end else if (PADDR_IN == ADDR_CTRL) begin
            rdata_d[CTRL_A_RUN] = timer_a_run_q;
            rdata_d[CTRL_A_OVF] = timer_a_overflow_flag_q;
            rdata_d[CTRL_B_RUN] = timer_b_run_q;
            rdata_d[CTRL_B_OVF] = timer_b_overflow_flag_q;
        end else if (PADDR_IN == ADDR_A_LOW) begin
            rdata_d[7:0] = cnt_a_q.low;
        end else if (PADDR_IN == ADDR_A_HIGH) begin
            rdata_d[7:0] = cnt_a_q.high;
        end else if (PADDR_IN == ADDR_B_LOW) begin
            rdata_d[7:0] = cnt_b_q.low;
        end else if (PADDR_IN == ADDR_B_HIGH) begin
            rdata_d[7:0] = cnt_b_q.high;
        end else begin
            rd_err = 1'b1;
        end
    end

    // Registered APB answer and interrupt outputs
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            PRDATA_OUT <= '0;
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            TIMER_A_IRQ_OUT <= 1'b0;
            TIMER_B_IRQ_OUT <= 1'b0;
        end else begin
            PREADY_OUT <= PSEL_IN && !PENABLE_IN;
            PSLVERR_OUT <= PSEL_IN && !PENABLE_IN && rd_err;
            PRDATA_OUT <= (PSEL_IN && !PENABLE_IN && !PWRITE_IN) ? rdata_d
                : '0;
            TIMER_A_IRQ_OUT <= timer_a_overflow_flag_q
                && TIMER_A_INT_ENABLE_IN;
            TIMER_B_IRQ_OUT <= timer_b_overflow_flag_q
                && TIMER_B_INT_ENABLE_IN;
        end
    end
endmodule : dtc_timer

`default_nettype wire
